// *** wake_pkg.sv ***
// Purpose: Shared constants for the wakeup frame filter block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Register offsets and the CRC-16 polynomial are local choices.

package wake_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int NUM_FILTERS   = 8;
   localparam int MASK_BITS     = 128;
   localparam int MASK_IDX_BITS = 7;
   localparam int MASK_WORDS    = 4;
   localparam int WORD_BITS     = 32;
   localparam int POS_BITS      = 11;
   localparam int ADDR_BITS     = 12;
   localparam int CRC_BITS      = 16;
   localparam int OFS_BITS      = 8;
   localparam int CMD_BITS      = 4;

   // ****************************************************************
   // CRC-16 engine
   // ****************************************************************
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h8005;

   // ****************************************************************
   // Register map: filter f at f * 0x20, globals from 0x100
   // ****************************************************************
   localparam int FILT_SEL_BIT = 8;
   localparam int FILT_IDX_LSB = 5;
   localparam int FILT_IDX_W   = 3;
   localparam int REG_IDX_LSB  = 2;
   localparam int REG_IDX_W    = 3;
   localparam logic [2:0] REG_MASK3_IDX = 3'h3;
   localparam logic [2:0] REG_CMD_IDX   = 3'h4;
   localparam logic [2:0] REG_OFS_IDX   = 3'h5;
   localparam logic [2:0] REG_CRC_IDX   = 3'h6;

   localparam logic [11:0] ADDR_WAKE_CTRL   = 12'h100;
   localparam logic [11:0] ADDR_WAKE_STATUS = 12'h104;
   localparam logic [11:0] ADDR_WAKE_CLEAR  = 12'h108;
   localparam logic [11:0] ADDR_WAKE_IRQ_EN = 12'h10c;
   localparam logic [11:0] ADDR_MAC_CTRL    = 12'h110;

   // ****************************************************************
   // Fields
   // ****************************************************************
   localparam int CMD_EN_BIT    = 0;
   localparam int CMD_ATYPE_LSB = 2;
   localparam logic [1:0] ATYPE_UNICAST   = 2'h0;
   localparam logic [1:0] ATYPE_MULTICAST = 2'h2;

   localparam int CTRL_WAKE_FRAME_EN_BIT = 0;
   localparam int CTRL_GLOBAL_UCAST_BIT  = 9;
   localparam int MACCTRL_BROADCAST_DISABLE_DIS_BIT  = 11;

   localparam int STAT_WAKE_BIT = 0;
   localparam int STAT_HIT_LSB  = 8;
   localparam int STAT_BITS     = 16;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

// *** crc16_unit.sv ***
// Purpose: Byte-wide CRC-16 accumulator for one wakeup filter.
// Assumes: One byte per feed cycle, most significant bit first.
// Notes:   A start cycle restarts the sum, and may also feed its byte.

module crc16_unit
   import wake_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                nrst,
   input  wire logic                start,
   input  wire logic                feed,
   input  wire logic [7:0]          data,
   output logic      [CRC_BITS-1:0] crc
);

   // ****************************************************************
   // Next value over one byte
   // ****************************************************************
   function automatic logic [CRC_BITS-1:0] crc_byte
   (
      input logic [CRC_BITS-1:0] c,
      input logic [7:0]          d
   );
      logic [CRC_BITS-1:0] r;
      logic                fb;
      r = c;
      for (int i = 7; i >= 0; i--)
      begin
         fb = r[CRC_BITS-1] ^ d[i];
         r  = {r[CRC_BITS-2:0], 1'b0};
         if (fb)
         begin
            r = r ^ CRC_POLY;
         end
      end
      return r;
   endfunction

   logic [CRC_BITS-1:0] base;

   assign base = start ? CRC_INIT : crc;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         crc <= CRC_INIT;
      end
      else if (feed)
      begin
         crc <= crc_byte(base, data);
      end
      else if (start)
      begin
         crc <= CRC_INIT;
      end
   end

endmodule

// *** wakeup_frame_filter.sv ***
// Purpose: Wakeup frame recognition in the MAC receive path, APB slave.
// Assumes: Receive bytes and frame class flags come from mclk logic.
// Notes:   Class flags are sampled on the last byte of the frame.
//
// What this block does
// - Masked bit j feeds frame byte offset plus j into the CRC.
// - Mask held as four words, word 0 low; lsb is earliest byte.
// - Address type 00 selects unicast, 10 selects multicast frames.
// - Address type with low bit set applies to regular-filter passes.
// - Command bit 0 enables the filter; bit 1 is reserved.
// - Eight-bit offset; zero is the first destination address byte.
// - Computed CRC equal to expected CRC-16 is a match.
// - Wake needs frame enable, enabled match, and a listed case.
// - Broadcast match wakes regardless of type and broadcast disable.
// - Unicast match wakes when global unicast bit 9 is set.
//
// The register addresses and the APB interface to the registers were decided locally.

module wakeup_frame_filter
   import wake_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 nrst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_BITS-1:0] paddr,
   input  wire logic [WORD_BITS-1:0] pwdata,
   output logic      [WORD_BITS-1:0] prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 rx_valid,
   input  wire logic                 rx_sof,
   input  wire logic                 rx_eof,
   input  wire logic [7:0]           rx_data,
   input  wire logic                 rx_broadcast_disable,
   input  wire logic                 rx_mcast,
   input  wire logic                 rx_pass_filter,
   output logic                      wake,
   output logic                      irq,
   output logic                      broadcast_disable
);

   // ****************************************************************
   // Register storage
   // ****************************************************************
   logic [MASK_BITS-1:0] filter_byte_select_mask [NUM_FILTERS];
   logic [CMD_BITS-1:0]  filter_command          [NUM_FILTERS];
   logic [OFS_BITS-1:0]  filter_pattern_offset   [NUM_FILTERS];
   logic [CRC_BITS-1:0]  filter_expected_crc     [NUM_FILTERS];
   logic [WORD_BITS-1:0] wake_control_status_reg;
   logic [STAT_BITS-1:0] wake_status;
   logic [STAT_BITS-1:0] wake_irq_enable;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   logic                  acc_start;
   logic                  wr_commit;
   logic                  in_filters;
   logic [FILT_IDX_W-1:0] sel_filt;
   logic [REG_IDX_W-1:0]  sel_reg;
   logic [WORD_BITS-1:0]  next_prdata;
   logic                  next_pslverr;
   logic                  wake_frame_enable;
   logic                  global_ucast;

   // Data is prepared in the first access cycle, so pready is a flop
   assign acc_start  = psel && penable && !pready;
   assign wr_commit  = psel && penable && pready && pwrite;
   assign in_filters = !paddr[FILT_SEL_BIT]
                       && (paddr[ADDR_BITS-1:FILT_SEL_BIT+1] == '0);
   assign sel_filt   = paddr[FILT_IDX_LSB +: FILT_IDX_W];
   assign sel_reg    = paddr[REG_IDX_LSB +: REG_IDX_W];

   assign wake_frame_enable = wake_control_status_reg[CTRL_WAKE_FRAME_EN_BIT];
   assign global_ucast      = wake_control_status_reg[CTRL_GLOBAL_UCAST_BIT];

   always_comb
   begin
      next_prdata  = RESET_WORD;
      next_pslverr = 1'b0;
      if (in_filters)
      begin
         if (sel_reg <= REG_MASK3_IDX)
         begin
            next_prdata = filter_byte_select_mask[sel_filt]
                          [sel_reg[1:0] * WORD_BITS +: WORD_BITS];
         end
         else if (sel_reg == REG_CMD_IDX)
         begin
            next_prdata[CMD_BITS-1:0] = filter_command[sel_filt];
         end
         else if (sel_reg == REG_OFS_IDX)
         begin
            next_prdata[OFS_BITS-1:0] = filter_pattern_offset[sel_filt];
         end
         else if (sel_reg == REG_CRC_IDX)
         begin
            next_prdata[CRC_BITS-1:0] = filter_expected_crc[sel_filt];
         end
         else
         begin
            next_pslverr = 1'b1;
         end
      end
      else if (paddr == ADDR_WAKE_CTRL)
      begin
         next_prdata = wake_control_status_reg;
      end
      else if (paddr == ADDR_WAKE_STATUS)
      begin
         next_prdata[STAT_BITS-1:0] = wake_status;
      end
      else if (paddr == ADDR_WAKE_CLEAR)
      begin
         // Write-only: reads as zero
         next_prdata = RESET_WORD;
      end
      else if (paddr == ADDR_WAKE_IRQ_EN)
      begin
         next_prdata[STAT_BITS-1:0] = wake_irq_enable;
      end
      else if (paddr == ADDR_MAC_CTRL)
      begin
         next_prdata[MACCTRL_BROADCAST_DISABLE_DIS_BIT] = broadcast_disable;
      end
      else
      begin
         next_pslverr = 1'b1;
      end
   end

   // ****************************************************************
   // Bus answer
   // ****************************************************************
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready  <= 1'b0;
         prdata  <= RESET_WORD;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= acc_start;
         pslverr <= acc_start && next_pslverr;
         if (acc_start && !pwrite)
         begin
            prdata <= next_prdata;
         end
      end
   end

   // ****************************************************************
   // Filter settings
   // ****************************************************************
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int f = 0; f < NUM_FILTERS; f++)
         begin
            filter_byte_select_mask[f] <= '0;
            filter_command[f]          <= '0;
            filter_pattern_offset[f]   <= '0;
            filter_expected_crc[f]     <= '0;
         end
      end
      else if (wr_commit && in_filters)
      begin
         if (sel_reg <= REG_MASK3_IDX)
         begin
            filter_byte_select_mask[sel_filt]
               [sel_reg[1:0] * WORD_BITS +: WORD_BITS] <= pwdata;
         end
         else if (sel_reg == REG_CMD_IDX)
         begin
            // Reserved bit 1 is kept as zero
            filter_command[sel_filt] <= pwdata[CMD_BITS-1:0]
                                        & 4'hd;
         end
         else if (sel_reg == REG_OFS_IDX)
         begin
            filter_pattern_offset[sel_filt] <= pwdata[OFS_BITS-1:0];
         end
         else if (sel_reg == REG_CRC_IDX)
         begin
            filter_expected_crc[sel_filt] <= pwdata[CRC_BITS-1:0];
         end
      end
   end

   // ****************************************************************
   // Global settings
   // ****************************************************************
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         wake_control_status_reg <= RESET_WORD;
         wake_irq_enable         <= '0;
         broadcast_disable       <= 1'b0;
      end
      else if (wr_commit)
      begin
         if (paddr == ADDR_WAKE_CTRL)
         begin
            wake_control_status_reg <= RESET_WORD;
            wake_control_status_reg[CTRL_WAKE_FRAME_EN_BIT] <=
               pwdata[CTRL_WAKE_FRAME_EN_BIT];
            wake_control_status_reg[CTRL_GLOBAL_UCAST_BIT] <=
               pwdata[CTRL_GLOBAL_UCAST_BIT];
         end
         if (paddr == ADDR_WAKE_IRQ_EN)
         begin
            wake_irq_enable <= pwdata[STAT_BITS-1:0];
         end
         if (paddr == ADDR_MAC_CTRL)
         begin
            broadcast_disable <= pwdata[MACCTRL_BROADCAST_DISABLE_DIS_BIT];
         end
      end
   end

   // ****************************************************************
   // Frame byte position
   // ****************************************************************
   logic [POS_BITS-1:0] pos;
   logic [POS_BITS-1:0] cur_pos;
   logic                frame_start;

   assign frame_start = rx_valid && rx_sof;
   // Position 0 is the first destination address byte
   assign cur_pos = rx_sof ? '0 : pos;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pos <= '0;
      end
      else if (rx_valid && (cur_pos != '1))
      begin
         // Saturates so long frames never wrap back into a window
         pos <= cur_pos + POS_BITS'(1);
      end
   end

   // ****************************************************************
   // Frame class capture and evaluation strobe
   // ****************************************************************
   logic eval_pending;
   logic fr_broadcast_disable;
   logic fr_mcast;
   logic fr_ucast;
   logic fr_pass;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         eval_pending <= 1'b0;
         fr_broadcast_disable     <= 1'b0;
         fr_mcast     <= 1'b0;
         fr_ucast     <= 1'b0;
         fr_pass      <= 1'b0;
      end
      else
      begin
         // CRC flops hold the final sum in the cycle after the last byte
         eval_pending <= rx_valid && rx_eof;
         if (rx_valid && rx_eof)
         begin
            fr_broadcast_disable <= rx_broadcast_disable;
            fr_mcast <= rx_mcast && !rx_broadcast_disable;
            fr_ucast <= !rx_mcast && !rx_broadcast_disable;
            fr_pass  <= rx_pass_filter;
         end
      end
   end

   // ****************************************************************
   // Per-filter CRC and match
   // ****************************************************************
   logic [NUM_FILTERS-1:0] hit;

   generate
      for (genvar gf = 0; gf < NUM_FILTERS; gf++)
      begin : g_filt
         logic [POS_BITS-1:0] ofs;
         logic [POS_BITS-1:0] rel;
         logic                in_win;
         logic                feed;
         logic [CRC_BITS-1:0] crc;
         logic [1:0]          atype;
         logic                class_ok;

         assign ofs    = POS_BITS'(filter_pattern_offset[gf]);
         assign rel    = cur_pos - ofs;
         // Window covers at most 128 bytes past the offset
         assign in_win = (cur_pos >= ofs)
                         && (rel < POS_BITS'(MASK_BITS));
         assign feed   = rx_valid && in_win
            && filter_byte_select_mask[gf][rel[MASK_IDX_BITS-1:0]];

         crc16_unit u_crc
         (
            .mclk  (mclk),
            .nrst  (nrst),
            .start (frame_start),
            .feed  (feed),
            .data  (rx_data),
            .crc   (crc)
         );

         assign atype = filter_command[gf][CMD_ATYPE_LSB +: 2];

         assign class_ok =
              fr_broadcast_disable
            || (global_ucast && fr_ucast)
            || (fr_pass && (atype[0]
               || ((atype == ATYPE_UNICAST) && fr_ucast)
               || ((atype == ATYPE_MULTICAST) && fr_mcast)));

         assign hit[gf] = filter_command[gf][CMD_EN_BIT]
                          && (crc == filter_expected_crc[gf])
                          && class_ok;
      end
   endgenerate

   // ****************************************************************
   // Wake decision
   // ****************************************************************
   logic                   wake_evt;
   logic [NUM_FILTERS-1:0] hit_evt;

   // Broadcast disable is deliberately not consulted here
   assign wake_evt = eval_pending && wake_frame_enable && (|hit);
   assign hit_evt  = wake_evt ? hit : '0;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         wake <= 1'b0;
      end
      else
      begin
         wake <= wake_evt;
      end
   end

   // ****************************************************************
   // Status, clear and interrupt
   // ****************************************************************
   logic [STAT_BITS-1:0] stat_set;
   logic [STAT_BITS-1:0] stat_clr;

   always_comb
   begin
      stat_set                = '0;
      stat_set[STAT_WAKE_BIT] = wake_evt;
      stat_set[STAT_HIT_LSB +: NUM_FILTERS] = hit_evt;
      stat_clr = (wr_commit && (paddr == ADDR_WAKE_CLEAR))
                 ? pwdata[STAT_BITS-1:0] : '0;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         wake_status <= '0;
      end
      else
      begin
         // A new event in the clearing cycle survives the clear
         wake_status <= (wake_status & ~stat_clr) | stat_set;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(wake_status & wake_irq_enable);
      end
   end

endmodule

// *** wake_filter_properties.sv ***
// Purpose: Port-level checker for the wakeup frame filter.
// Assumes: One clock domain; nrst low disables every property.
// Notes:   Config state is not visible here, so wake is tied to eof.

module wake_filter_checker
   import wake_pkg::*;
(
   input wire logic                 mclk,
   input wire logic                 nrst,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [ADDR_BITS-1:0] paddr,
   input wire logic [WORD_BITS-1:0] pwdata,
   input wire logic [WORD_BITS-1:0] prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 rx_valid,
   input wire logic                 rx_sof,
   input wire logic                 rx_eof,
   input wire logic [7:0]           rx_data,
   input wire logic                 rx_broadcast_disable,
   input wire logic                 rx_mcast,
   input wire logic                 rx_pass_filter,
   input wire logic                 wake,
   input wire logic                 irq,
   input wire logic                 broadcast_disable
);
   timeunit 1ns;
   timeprecision 1ps;

   logic apb_wr;

   assign apb_wr = psel && penable && pready && pwrite;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   property p_ready_time;
      $rose(penable) && psel |-> !pready ##1 pready ##1 !pready;
   endproperty
   a_ready_time : assert property (p_ready_time)
      else $error("pready not in second access cycle");

   property p_ready_access;
      pready |-> psel && penable && $past(psel && penable);
   endproperty
   a_ready_access : assert property (p_ready_access)
      else $error("pready outside an access phase");

   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready : assert property (p_err_ready)
      else $error("pslverr without pready");

   property p_prdata_hold;
      $changed(prdata) |-> $past(psel && penable && !pwrite);
   endproperty
   a_prdata_hold : assert property (p_prdata_hold)
      else $error("prdata changed outside a read");

   // Wake is two samples behind the eof byte
   property p_wake_cause;
      wake |-> $past(rx_valid && rx_eof, 2);
   endproperty
   a_wake_cause : assert property (p_wake_cause)
      else $error("wake without a frame end");

   property p_irq_rise;
      $rose(irq) |-> $past(wake)
         || $past(apb_wr && paddr == ADDR_WAKE_IRQ_EN, 2);
   endproperty
   a_irq_rise : assert property (p_irq_rise)
      else $error("irq rose without a cause");

   property p_irq_fall;
      $fell(irq) |-> $past(apb_wr && (paddr == ADDR_WAKE_CLEAR
         || paddr == ADDR_WAKE_IRQ_EN), 2);
   endproperty
   a_irq_fall : assert property (p_irq_fall)
      else $error("irq fell without a clear");

   property p_broadcast_disable_dis;
      apb_wr && paddr == ADDR_MAC_CTRL
         |=> broadcast_disable == $past(pwdata[MACCTRL_BROADCAST_DISABLE_DIS_BIT]);
   endproperty
   a_broadcast_disable_dis : assert property (p_broadcast_disable_dis)
      else $error("broadcast_disable not taken from write");

   c_wake : cover property (wake);
   c_err : cover property (pslverr);
   c_irq : cover property ($rose(irq));
endmodule

// *** remote_station.sv ***
// Purpose: Far station model feeding received frame bytes.
// Assumes: Bytes of one frame arrive on consecutive cycles.
// Notes:   Idle data carries the inverted last byte so stale data never matches; class flags keep their last-byte values.

module remote_station
(
   input  wire logic       mclk,
   output logic            rx_valid,
   output logic            rx_sof,
   output logic            rx_eof,
   output logic [7:0]      rx_data,
   output logic            rx_broadcast_disable,
   output logic            rx_mcast,
   output logic            rx_pass_filter
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      rx_valid = 1'b0;
      rx_sof = 1'b0;
      rx_eof = 1'b0;
      rx_data = 8'h00;
      rx_broadcast_disable = 1'b0;
      rx_mcast = 1'b0;
      rx_pass_filter = 1'b0;
   end

   // Class flags are wrong except on the last byte
   task automatic send(input logic [7:0] f [64], input int len,
                       input logic b, input logic m, input logic p);
      for (int i = 0; i < len; i++)
      begin
         @(posedge mclk);
         rx_valid <= 1'b1;
         rx_sof <= (i == 0);
         rx_eof <= (i == len - 1);
         rx_data <= f[i];
         rx_broadcast_disable <= (i == len - 1) ? b : !b;
         rx_mcast <= (i == len - 1) ? m : !m;
         rx_pass_filter <= (i == len - 1) ? p : !p;
      end
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_sof <= 1'b0;
      rx_eof <= 1'b0;
      rx_data <= ~f[len - 1];
   endtask
endmodule

// *** testbench.sv ***
// Purpose: Self-checking bench for the wakeup frame filter.
// Assumes: Filter 0 only; random frame bytes from a fixed seed.
// Notes:   Row digits: cmd, global ucast, wake en, class, pass, flaw, exp.

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import wake_pkg::*;

   localparam logic [127:0] MSK = {64'h0, 32'h0000_0102, 32'h0000_0007};
   localparam int OFS = 3;
   localparam int LEN = 60;
   localparam logic [27:0] ROWS [15] = '{
      28'h1010101, 28'h1010000, 28'h1011100,
      28'h9011101, 28'h9010100,
      28'h5011101, 28'hd010101, 28'h5011000,
      28'h8012000,
      28'h9012001,
      28'h1110001, 28'h9110001,
      28'h1100100,
      28'h1010110,
      28'h1010121
   };

   logic        mclk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        rx_valid, rx_sof, rx_eof, rx_broadcast_disable, rx_mcast, rx_pass;
   logic [7:0]  rx_data;
   logic        wake, irq, bdis;
   logic [32:0] rq[$];
   logic        wq[$];
   logic [2:0]  eof_d;
   logic [7:0]  frm [64];
   logic [7:0]  fr2 [64];
   int          err_total, compares, cycles, seed;

   wakeup_frame_filter dut_u (.mclk(mclk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
      .rx_data(rx_data), .rx_broadcast_disable(rx_broadcast_disable), .rx_mcast(rx_mcast),
      .rx_pass_filter(rx_pass), .wake(wake), .irq(irq),
      .broadcast_disable(bdis));

   remote_station station_u (.mclk(mclk), .rx_valid(rx_valid),
      .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data),
      .rx_broadcast_disable(rx_broadcast_disable), .rx_mcast(rx_mcast), .rx_pass_filter(rx_pass));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   function automatic logic [15:0] crc_of(input logic [7:0] f [64]);
      logic [15:0] c;
      c = CRC_INIT;
      for (int p = OFS; p < 64; p++)
         if (MSK[p - OFS])
            for (int i = 7; i >= 0; i--)
               c = {c[14:0], 1'b0} ^ ((c[15] ^ f[p][i]) ? CRC_POLY : 16'h0);
      return c;
   endfunction

   task automatic chk(input string nm, input logic [32:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Only the bench's cycle ceiling ends a wait that never sees pready
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   always @(posedge mclk)
   begin
      eof_d <= {eof_d[1:0], rx_valid & rx_eof};
      if (psel && penable && pready && !pwrite && rq.size() > 0)
         chk("read", {pslverr, prdata}, rq.pop_front());
      // Wake is sampled high at the second edge after the eof byte
      if (eof_d[1] && wq.size() > 0)
         chk("wake", {32'h0, wake}, {32'h0, wq.pop_front()});
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         test_done();
      end
   end

   initial
   begin
      logic [27:0] row;
      seed = 6909;
      err_total = 0;
      compares = 0;
      cycles = 0;
      eof_d = 3'h0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      for (int i = 0; i < 64; i++)
         frm[i] = 8'($random(seed));
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      rd(ADDR_WAKE_CTRL, 33'h0);
      rd(12'h01c, 33'h1_0000_0000);
      rd(12'h010, 33'h0);
      for (int k = 0; k < 4; k++)
         apb(1'b1, 12'(4 * k), MSK[32 * k +: 32]);
      apb(1'b1, 12'h014, 32'(OFS));
      apb(1'b1, 12'h018, {16'h0, crc_of(frm)});
      apb(1'b1, 12'h010, 32'hf);
      rd(12'h010, 33'hd);
      apb(1'b1, ADDR_MAC_CTRL, 32'h800);
      rd(ADDR_MAC_CTRL, 33'h800);
      chk("broadcast_disable", {32'h0, bdis}, 33'h1);
      apb(1'b1, ADDR_WAKE_IRQ_EN, 32'h1);
      for (int i = 0; i < 15; i++)
      begin
         row = ROWS[i];
         fr2 = frm;
         if (row[7:4] == 4'h1)
            fr2[36] = frm[36] ^ 8'h01;
         if (row[7:4] == 4'h2)
         begin
            fr2[2] = ~frm[2];
            fr2[6] = ~frm[6];
         end
         apb(1'b1, 12'h010, {28'h0, row[27:24]});
         apb(1'b1, ADDR_WAKE_CTRL, {22'h0, row[20], 8'h0, row[16]});
         wq.push_back(row[0]);
         station_u.send(fr2, LEN, row[13], row[12], row[8]);
      end
      repeat (4) @(posedge mclk);
      rd(ADDR_WAKE_STATUS, 33'h101);
      apb(1'b1, ADDR_WAKE_STATUS, 32'h0);
      rd(ADDR_WAKE_STATUS, 33'h101);
      chk("irq", {32'h0, irq}, 33'h1);
      apb(1'b1, ADDR_WAKE_IRQ_EN, 32'h0);
      repeat (2) @(negedge mclk);
      chk("irq", {32'h0, irq}, 33'h0);
      apb(1'b1, ADDR_WAKE_IRQ_EN, 32'h101);
      repeat (2) @(negedge mclk);
      chk("irq", {32'h0, irq}, 33'h1);
      apb(1'b1, ADDR_WAKE_CLEAR, 32'h101);
      repeat (2) @(negedge mclk);
      chk("irq", {32'h0, irq}, 33'h0);
      rd(ADDR_WAKE_STATUS, 33'h0);
      rd(ADDR_WAKE_CLEAR, 33'h0);
      rd(12'h1fc, 33'h1_0000_0000);
      // Let the monitor take the last read before counting leftovers
      @(posedge mclk);
      chk("pending", 33'(rq.size() + wq.size()), 33'h0);
      test_done();
   end
endmodule

bind wakeup_frame_filter wake_filter_checker chk_u (.mclk(mclk),
   .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx_valid(rx_valid), .rx_sof(rx_sof),
   .rx_eof(rx_eof), .rx_data(rx_data), .rx_broadcast_disable(rx_broadcast_disable),
   .rx_mcast(rx_mcast), .rx_pass_filter(rx_pass_filter), .wake(wake),
   .irq(irq), .broadcast_disable(broadcast_disable));
